// ==== verilog/timer_pwm_unit.sv ====
`timescale 1ns/1ps

// Operation
// - Reset clears main control, counter clock off
// - Reset leaves channels input capture, pins released
// - Capture edge or counter match sets flag
// - Level interrupt high while enabled flag set
// - Flag cleared by read-set then write-zero
// - New event between steps keeps flag set
// - Edge mode overflow at modulo-to-zero rollover
// - Center mode overflow at up-to-down turn
// - Edge select: off, rising, falling, both
// - Edge PWM flag at duty end match
// - Center PWM flag at both matches
// - Counter write clears counter and prescaler
// - Halted counter reads return live value
// - Halted control or counter write drops latch
// - Halted value reads live; channel control write drops latch
// - Capture channels ignore value writes
// - Compare loads buffer on next counter step
// - PWM loads buffer stepping into modulo
// - Center value equal modulo gives full duty
// - Zero-to-nonzero change waits for new period
// - Nonzero-to-zero change finishes current period
// - Main control write resets modulo coherency
// - Channel control write discards buffered value
// - Clock off: buffer loads on second byte
module timer_pwm_unit #(
   parameter int NUM_CH = 2
) (
   input  wire logic                                pclk,         // Bus clock
   input  wire logic                                presetn,      // Async reset, active low
   input  wire logic                                clk_en,       // Freezes all state when low
   input  wire logic                                psel,         // APB select
   input  wire logic                                penable,      // APB enable
   input  wire logic                                pwrite,       // APB direction
   input  wire logic [timer_pwm_pkg::ADDR_W-1:0]    paddr,        // APB byte address
   input  wire logic [31:0]                         pwdata,       // APB write data
   output logic      [31:0]                         prdata,       // APB read data
   output logic                                     pready,       // APB ready
   output logic                                     pslverr,      // APB error, unmapped
   input  wire logic                                debug_halt,   // Background debug halt
   input  wire logic                                ext_clk_tick, // Alternate count source
   input  wire logic [NUM_CH-1:0]                   ch_in,        // Channel pin levels
   output logic      [NUM_CH-1:0]                   ch_out,       // Channel pin drive
   output logic      [NUM_CH-1:0]                   ch_oe_n,      // Low while pin driven
   output logic                                     irq           // Interrupt, active high
);

   typedef struct packed {
      logic                                ovf_flag, ovf_arm, ovf_ie, center;
      logic [1:0]                          clk_sel;
      logic [2:0]                          presc;
      logic [15:0]                         cnt;
      logic [timer_pwm_pkg::PRE_W-1:0]     pre_cnt;
      logic                                dir_down;
      logic [15:0]                         mod, mod_buf;
      logic                                mod_hi_wr, mod_lo_wr, mod_pend;
      logic [7:0]                          cnt_lat;
      logic                                cnt_lat_v;
      logic [NUM_CH-1:0]                   ch_flag, ch_arm, ch_ie;
      logic [NUM_CH-1:0][1:0]              mode, els;
      logic [NUM_CH-1:0][15:0]             val, vbuf, duty;
      logic [NUM_CH-1:0]                   v_hi_wr, v_lo_wr;
      logic [NUM_CH-1:0][7:0]              v_lat;
      logic [NUM_CH-1:0]                   v_lat_v;
      logic [NUM_CH-1:0]                   pin_prev, pin_out, pin_oe_n;
      logic [31:0]                         rdata;
      logic                                ready, err, irq;
   } state_s;

   // Everything zero but pin_oe_n: clock off, overflow irq off, all channels capture, pins released
   localparam state_s RST_S = '{pin_oe_n: '1, default: '0};

   state_s state_reg;
   state_s state_next;

   function automatic logic [timer_pwm_pkg::ADDR_W-1:0] ch_addr(input int idx, input int off);
      return timer_pwm_pkg::ADDR_W'(timer_pwm_pkg::CH_BASE + idx * timer_pwm_pkg::CH_STRIDE + off);
   endfunction : ch_addr

   always_comb
   begin
      logic                              acc_start, acc_done, rd, wr, halt, wr_cnt, hit;
      logic                              src, tick, ovf_ev, top_step;
      logic                              ic, oc, ep, ev, rise, fall, on;
      logic [7:0]                        rbyte;
      logic [15:0]                       cnt_new, mod_eff, d;
      logic [timer_pwm_pkg::PRE_W-1:0]   pre_max;
      // Ready one cycle into the access phase; effects happen on the completing edge
      acc_start = psel && penable && !state_reg.ready;
      acc_done  = psel && penable && state_reg.ready;
      rd        = acc_done && !pwrite;
      wr        = acc_done && pwrite;
      halt      = debug_halt;
      wr_cnt    = wr && (paddr == timer_pwm_pkg::CNT_HI_OFF || paddr == timer_pwm_pkg::CNT_LO_OFF);
      hit       = 1'b0;
      src       = 1'b0;
      tick      = 1'b0;
      ovf_ev    = 1'b0;
      top_step  = 1'b0;
      ic        = 1'b0;
      oc        = 1'b0;
      ep        = 1'b0;
      ev        = 1'b0;
      rise      = 1'b0;
      fall      = 1'b0;
      on        = 1'b0;
      rbyte     = 8'h00;
      cnt_new   = state_reg.cnt;
      mod_eff   = state_reg.mod;
      d         = 16'h0000;
      pre_max   = '0;

      state_next       = state_reg;
      state_next.ready = 1'b0;
      state_next.err   = 1'b0;

      if (acc_start)
      begin
         hit = 1'b1;
         case (paddr)
            timer_pwm_pkg::SC_OFF:
               rbyte = {state_reg.ovf_flag, state_reg.ovf_ie, state_reg.center,
                        state_reg.clk_sel, state_reg.presc};
            timer_pwm_pkg::CNT_HI_OFF: rbyte = state_reg.cnt[15:8];
            timer_pwm_pkg::CNT_LO_OFF:
               rbyte = (state_reg.cnt_lat_v && !halt) ? state_reg.cnt_lat
                                                      : state_reg.cnt[7:0];
            timer_pwm_pkg::MOD_HI_OFF: rbyte = state_reg.mod[15:8];
            timer_pwm_pkg::MOD_LO_OFF: rbyte = state_reg.mod[7:0];
            default: hit = 1'b0;
         endcase
         for (int i = 0; i < NUM_CH; i++)
         begin
            if (paddr == ch_addr(i, timer_pwm_pkg::CH_SC_OFF))
            begin
               hit   = 1'b1;
               rbyte = {state_reg.ch_flag[i], state_reg.ch_ie[i], state_reg.mode[i],
                        state_reg.els[i], 2'h0};
            end
            if (paddr == ch_addr(i, timer_pwm_pkg::CH_VHI_OFF))
            begin
               hit   = 1'b1;
               rbyte = state_reg.val[i][15:8];
            end
            if (paddr == ch_addr(i, timer_pwm_pkg::CH_VLO_OFF))
            begin
               hit   = 1'b1;
               rbyte = (state_reg.v_lat_v[i] && !halt) ? state_reg.v_lat[i]
                                                       : state_reg.val[i][7:0];
            end
         end
         state_next.ready = 1'b1;
         state_next.rdata = {24'h000000, rbyte};
         state_next.err   = !hit;
      end

      // Main register side effects
      if (rd && paddr == timer_pwm_pkg::SC_OFF && state_reg.ovf_flag)
         state_next.ovf_arm = 1'b1;
      if (rd && paddr == timer_pwm_pkg::CNT_HI_OFF && !halt)
      begin
         state_next.cnt_lat   = state_reg.cnt[7:0];
         state_next.cnt_lat_v = 1'b1;
      end
      if (rd && paddr == timer_pwm_pkg::CNT_LO_OFF)
         state_next.cnt_lat_v = 1'b0;
      if (wr && paddr == timer_pwm_pkg::SC_OFF)
      begin
         if (state_reg.ovf_arm && !pwdata[timer_pwm_pkg::SC_FLAG_BIT])
            state_next.ovf_flag = 1'b0;
         state_next.ovf_arm   = 1'b0;
         state_next.ovf_ie    = pwdata[timer_pwm_pkg::SC_IE_BIT];
         state_next.center    = pwdata[timer_pwm_pkg::SC_CENTER_ALIGN_SELECT_BIT];
         state_next.clk_sel   = pwdata[timer_pwm_pkg::SC_CLKS_LSB +: 2];
         state_next.presc     = pwdata[timer_pwm_pkg::SC_PS_LSB +: 3];
         state_next.mod_hi_wr = 1'b0;
         state_next.mod_lo_wr = 1'b0;
         state_next.mod_pend  = 1'b0;
         if (halt)
            state_next.cnt_lat_v = 1'b0;
      end
      if (wr_cnt && halt)
         state_next.cnt_lat_v = 1'b0;
      if (wr && paddr == timer_pwm_pkg::MOD_HI_OFF)
      begin
         state_next.mod_buf[15:8] = pwdata[7:0];
         state_next.mod_hi_wr     = 1'b1;
      end
      if (wr && paddr == timer_pwm_pkg::MOD_LO_OFF)
      begin
         state_next.mod_buf[7:0] = pwdata[7:0];
         state_next.mod_lo_wr    = 1'b1;
      end
      if (state_next.mod_hi_wr && state_next.mod_lo_wr)
      begin
         state_next.mod_hi_wr = 1'b0;
         state_next.mod_lo_wr = 1'b0;
         if (state_reg.clk_sel == timer_pwm_pkg::CLK_OFF)
            state_next.mod = state_next.mod_buf;
         else
            state_next.mod_pend = 1'b1;
      end

      // Prescaler and main counter; the counter is frozen while halted
      pre_max = timer_pwm_pkg::PRE_W'((8'h01 << state_reg.presc) - 8'h01);
      src     = (state_reg.clk_sel == timer_pwm_pkg::CLK_BUS) || ext_clk_tick;
      mod_eff = (state_reg.mod == timer_pwm_pkg::MOD_ZERO) ? timer_pwm_pkg::MOD_FREE
                                                           : state_reg.mod;
      if (wr_cnt)
      begin
         state_next.cnt      = 16'h0000;
         state_next.pre_cnt  = '0;
         state_next.dir_down = 1'b0;
      end
      else if (state_reg.clk_sel != timer_pwm_pkg::CLK_OFF && !halt && src)
      begin
         if (state_reg.pre_cnt >= pre_max)
         begin
            state_next.pre_cnt = '0;
            tick               = 1'b1;
         end
         else
            state_next.pre_cnt = state_reg.pre_cnt + 1'b1;
      end
      if (tick)
      begin
         top_step = (state_reg.cnt == mod_eff - timer_pwm_pkg::ONE16) && !state_reg.dir_down;
         if (!state_reg.center)
         begin
            if (state_reg.cnt == mod_eff)
            begin
               cnt_new = 16'h0000;
               ovf_ev  = 1'b1;
            end
            else
               cnt_new = state_reg.cnt + timer_pwm_pkg::ONE16;
         end
         else if (!state_reg.dir_down)
         begin
            if (state_reg.cnt >= state_reg.mod)
            begin
               cnt_new             = state_reg.cnt - timer_pwm_pkg::ONE16;
               state_next.dir_down = 1'b1;
               ovf_ev              = 1'b1;
            end
            else
               cnt_new = state_reg.cnt + timer_pwm_pkg::ONE16;
         end
         else if (state_reg.cnt == 16'h0000)
         begin
            cnt_new             = timer_pwm_pkg::ONE16;
            state_next.dir_down = 1'b0;
         end
         else
            cnt_new = state_reg.cnt - timer_pwm_pkg::ONE16;
         state_next.cnt = cnt_new;
         if (state_reg.mod_pend && state_next.mod_pend)
         begin
            state_next.mod      = state_reg.mod_buf;
            state_next.mod_pend = 1'b0;
         end
      end
      if (ovf_ev)
      begin
         state_next.ovf_flag = 1'b1;
         state_next.ovf_arm  = 1'b0;
      end

      for (int i = 0; i < NUM_CH; i++)
      begin
         ic   = !state_reg.center && state_reg.mode[i] == timer_pwm_pkg::MS_IC;
         oc   = !state_reg.center && state_reg.mode[i] == timer_pwm_pkg::MS_OC;
         ep   = !state_reg.center && state_reg.mode[i][1];
         ev   = 1'b0;
         rise = ch_in[i] && !state_reg.pin_prev[i];
         fall = !ch_in[i] && state_reg.pin_prev[i];
         state_next.pin_prev[i] = ch_in[i];

         if (rd && paddr == ch_addr(i, timer_pwm_pkg::CH_SC_OFF) && state_reg.ch_flag[i])
            state_next.ch_arm[i] = 1'b1;
         if (rd && paddr == ch_addr(i, timer_pwm_pkg::CH_VHI_OFF) && !halt)
         begin
            state_next.v_lat[i]   = state_reg.val[i][7:0];
            state_next.v_lat_v[i] = 1'b1;
         end
         if (rd && paddr == ch_addr(i, timer_pwm_pkg::CH_VLO_OFF))
            state_next.v_lat_v[i] = 1'b0;
         if (wr && paddr == ch_addr(i, timer_pwm_pkg::CH_SC_OFF))
         begin
            if (state_reg.ch_arm[i] && !pwdata[timer_pwm_pkg::CH_FLAG_BIT])
               state_next.ch_flag[i] = 1'b0;
            state_next.ch_arm[i]  = 1'b0;
            state_next.ch_ie[i]   = pwdata[timer_pwm_pkg::CH_IE_BIT];
            state_next.mode[i]    = pwdata[timer_pwm_pkg::CH_MS_LSB +: 2];
            state_next.els[i]     = pwdata[timer_pwm_pkg::CH_ELS_LSB +: 2];
            state_next.v_hi_wr[i] = 1'b0;
            state_next.v_lo_wr[i] = 1'b0;
            state_next.v_lat_v[i] = 1'b0;
         end
         if (wr && paddr == ch_addr(i, timer_pwm_pkg::CH_VHI_OFF) && !ic)
         begin
            state_next.vbuf[i][15:8] = pwdata[7:0];
            state_next.v_hi_wr[i]    = 1'b1;
         end
         if (wr && paddr == ch_addr(i, timer_pwm_pkg::CH_VLO_OFF) && !ic)
         begin
            state_next.vbuf[i][7:0] = pwdata[7:0];
            state_next.v_lo_wr[i]   = 1'b1;
         end
         if (state_next.v_hi_wr[i] && state_next.v_lo_wr[i])
         begin
            if (state_reg.clk_sel == timer_pwm_pkg::CLK_OFF
                || (state_reg.v_hi_wr[i] && state_reg.v_lo_wr[i]
                    && ((oc && tick) || (!oc && !ic && top_step))))
            begin
               state_next.val[i]     = state_next.vbuf[i];
               state_next.v_hi_wr[i] = 1'b0;
               state_next.v_lo_wr[i] = 1'b0;
            end
         end

         if (ic)
         begin
            if ((state_reg.els[i][0] && rise) || (state_reg.els[i][1] && fall))
            begin
               state_next.val[i] = state_reg.cnt;
               ev                = 1'b1;
            end
         end
         else if (tick && cnt_new == state_reg.val[i])
            ev = 1'b1;

         if (oc && ev)
         begin
            if (state_reg.els[i] == timer_pwm_pkg::ELS_TOG)
               state_next.pin_out[i] = !state_reg.pin_out[i];
            else if (state_reg.els[i] != timer_pwm_pkg::ELS_OFF)
               state_next.pin_out[i] = state_reg.els[i] != timer_pwm_pkg::ELS_CLR;
         end
         else if (ep)
         begin
            // Match wins over rollover so a zero value gives 0% duty
            if (ev)
               state_next.pin_out[i] = state_reg.els[i][0];
            else if (ovf_ev)
               state_next.pin_out[i] = !state_reg.els[i][0];
         end

         // Center duty only changes at a period start, so old setting finishes the period
         if (state_reg.center)
         begin
            if (ovf_ev)
               state_next.duty[i] = state_reg.val[i];
            d  = state_reg.duty[i];
            on = d != 16'h0000 && !d[15] && (state_next.cnt < d || d >= state_reg.mod);
            state_next.pin_out[i] = on ^ state_reg.els[i][0];
         end
         else
            state_next.duty[i] = state_next.val[i];

         state_next.pin_oe_n[i] = ic || state_reg.els[i] == timer_pwm_pkg::ELS_OFF;

         if (ev)
         begin
            state_next.ch_flag[i] = 1'b1;
            state_next.ch_arm[i]  = 1'b0;
         end
      end

      state_next.irq = state_next.ovf_flag && state_next.ovf_ie;
      for (int i = 0; i < NUM_CH; i++)
         state_next.irq = state_next.irq || (state_next.ch_flag[i] && state_next.ch_ie[i]);

      if (!clk_en)
         state_next = state_reg;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         state_reg <= RST_S;
      else
         state_reg <= state_next;
   end

   assign prdata  = state_reg.rdata;
   assign pready  = state_reg.ready;
   assign pslverr = state_reg.err;
   assign ch_out  = state_reg.pin_out;
   assign ch_oe_n = state_reg.pin_oe_n;
   assign irq     = state_reg.irq;

endmodule : timer_pwm_unit

// ==== verilog/timer_pwm_pkg.sv ====
package timer_pwm_pkg;

   localparam int ADDR_W = 8;
   localparam int PRE_W  = 7;

   // Byte addresses of the main registers
   localparam logic [ADDR_W-1:0] SC_OFF     = 8'h00;
   localparam logic [ADDR_W-1:0] CNT_HI_OFF = 8'h04;
   localparam logic [ADDR_W-1:0] CNT_LO_OFF = 8'h08;
   localparam logic [ADDR_W-1:0] MOD_HI_OFF = 8'h0c;
   localparam logic [ADDR_W-1:0] MOD_LO_OFF = 8'h10;

   // Channel n block sits at CH_BASE + n * CH_STRIDE
   localparam int CH_BASE    = 'h20;
   localparam int CH_STRIDE  = 'h10;
   localparam int CH_SC_OFF  = 'h0;
   localparam int CH_VHI_OFF = 'h4;
   localparam int CH_VLO_OFF = 'h8;

   // Main status/control fields
   localparam int SC_FLAG_BIT  = 7;
   localparam int SC_IE_BIT    = 6;
   localparam int SC_CENTER_ALIGN_SELECT_BIT = 5;
   localparam int SC_CLKS_LSB  = 3;
   localparam int SC_PS_LSB    = 0;

   // Channel status/control fields
   localparam int CH_FLAG_BIT = 7;
   localparam int CH_IE_BIT   = 6;
   localparam int CH_MS_LSB   = 4;
   localparam int CH_ELS_LSB  = 2;

   localparam logic [1:0] CLK_OFF  = 2'h0;
   localparam logic [1:0] CLK_BUS  = 2'h1;
   localparam logic [1:0] MS_IC    = 2'h0;
   localparam logic [1:0] MS_OC    = 2'h1;
   localparam logic [1:0] ELS_OFF  = 2'h0;
   localparam logic [1:0] ELS_TOG  = 2'h1;
   localparam logic [1:0] ELS_CLR  = 2'h2;

   localparam logic [15:0] MOD_ZERO = 16'h0000;
   localparam logic [15:0] MOD_FREE = 16'hffff;
   localparam logic [15:0] ONE16    = 16'h0001;

endpackage : timer_pwm_pkg

// ==== tb/timer_pwm_monitor.sv ====
`timescale 1ns/1ps
module timer_pwm_monitor #(
   parameter int NUM_CH = 2
) (
   input wire logic                             pclk,    // Bus clock
   input wire logic                             presetn, // Reset, active low
   input wire logic                             clk_en,  // Clock enable
   input wire logic                             psel,    // APB select
   input wire logic                             penable, // APB enable
   input wire logic                             pwrite,  // APB direction
   input wire logic [timer_pwm_pkg::ADDR_W-1:0] paddr,   // APB address
   input wire logic [31:0]                      prdata,  // APB read data
   input wire logic                             pready,  // APB ready
   input wire logic                             pslverr, // APB error
   input wire logic [NUM_CH-1:0]                ch_oe_n, // Pin release
   input wire logic                             irq      // Interrupt
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic wr_done;
   assign wr_done = psel && penable && pready && pwrite;
   AST_RST_QUIET: assert property ($rose(presetn) |-> !irq && (&ch_oe_n))
      else $error("irq or pin drive active after reset");
   AST_READY_PULSE: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   AST_ONE_WAIT: assert property (psel && penable && !pready && clk_en |=> pready)
      else $error("pready late");
   AST_ERR_READY: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   AST_RDATA_BYTE: assert property (pready |-> prdata[31:8] == 24'h0)
      else $error("upper read data not zero");
   AST_UNMAPPED: assert property (pready && paddr >= 8'h20 + 8'h10 * NUM_CH |-> pslverr)
      else $error("unmapped access not refused");
   // Flags only drop through a completed software write, never by themselves
   AST_IRQ_FALL: assert property ($fell(irq) |-> $past(wr_done, 1) || $past(wr_done, 2)
      || $past(wr_done, 3)) else $error("irq fell without a write");
   AST_OE_CHANGE: assert property ($changed(ch_oe_n) |-> $past(wr_done, 1) || $past(wr_done, 2))
      else $error("pin drive changed without a write");
endmodule : timer_pwm_monitor

bind timer_pwm_unit timer_pwm_monitor #(.NUM_CH(NUM_CH)) i_mon (.pclk(pclk), .presetn(presetn),
   .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .ch_oe_n(ch_oe_n), .irq(irq));

// ==== tb/pin_stim.sv ====
`timescale 1ns/1ps
module pin_stim #(
   parameter int NUM_CH = 2
) (
   input  wire logic              pclk,       // Bus clock
   input  wire logic              en,         // Run edges on the pins
   output logic      [NUM_CH-1:0] ch_in = '0  // Channel pin levels
);
   int cnt = 0;
   // Slow square wave: each level lasts six cycles so no edge is lost
   always @(posedge pclk)
   begin
      cnt <= en ? cnt + 1 : 0;
      if (en && cnt % 6 == 5)
         ch_in <= ~ch_in;
   end
endmodule : pin_stim

// ==== tb/timer_pwm_irq_and_buffer_update_tb.sv ====
`timescale 1ns/1ps
module timer_pwm_irq_and_buffer_update_tb;
   localparam int NUM_CH = 2;
   logic              pclk       = 1'b0;
   logic              presetn    = 1'b0;
   logic              psel       = 1'b0;
   logic              penable    = 1'b0;
   logic              pwrite     = 1'b0;
   logic              debug_halt = 1'b0;
   logic              pin_en     = 1'b0;
   logic [7:0]        paddr      = 8'h00;
   logic [31:0]       pwdata     = 32'h0;
   logic [31:0]       prdata;
   logic              pready;
   logic              pslverr;
   logic              irq;
   logic [NUM_CH-1:0] ch_in;
   logic [NUM_CH-1:0] ch_out;
   logic [NUM_CH-1:0] ch_oe_n;
   logic [7:0]        rd;
   logic              er;
   logic [15:0]       v;
   logic [15:0]       m;
   logic [15:0]       g16;
   logic [7:0]        offs [11] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h20,
                                    8'h24, 8'h28, 8'h30, 8'h34, 8'h38};
   int                miscompares = 0;
   int                checks_done = 0;
   int                cycles      = 0;
   int                seed        = 50692;
   int                n;

   always #20 pclk = ~pclk;
   always @(posedge pclk) if (++cycles == 20000) test_done();

   timer_pwm_unit #(.NUM_CH(NUM_CH)) i_dut (.pclk(pclk), .presetn(presetn), .clk_en(1'b1),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .debug_halt(debug_halt),
      .ext_clk_tick(1'b0), .ch_in(ch_in), .ch_out(ch_out), .ch_oe_n(ch_oe_n), .irq(irq));
   pin_stim #(.NUM_CH(NUM_CH)) i_pins (.pclk(pclk), .en(pin_en), .ch_in(ch_in));

   task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      // No fixed wait assumed; only the cycle ceiling ends a hung transfer
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata[7:0];
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task chk(input string s, input logic [15:0] e, input logic [15:0] g);
      checks_done++;
      if (g !== e)
      begin
         $display("[ERR] %s expected %h seen %h", s, e, g);
         miscompares++;
      end
   endtask : chk

   // High byte first so the low byte comes from the coherency latch
   task rd16(input logic [7:0] a);
      apb(1'b0, a, 8'h00);
      g16[15:8] = rd;
      apb(1'b0, a + 8'h04, 8'h00);
      g16[7:0] = rd;
   endtask : rd16

   task wr16(input logic [7:0] a, input logic [15:0] d);
      apb(1'b1, a, d[15:8]);
      apb(1'b1, a + 8'h04, d[7:0]);
   endtask : wr16

   function logic [7:0] chsc(input logic f, input logic [1:0] ms);
      return {f, 1'b0, ms, timer_pwm_pkg::ELS_TOG, 2'b00};
   endfunction : chsc

   task test_done;
      miscompares += (cycles >= 20000);
      $display("checks %0d miscompares %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : test_done

   initial
   begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      foreach (offs[i])
      begin
         apb(1'b0, offs[i], 8'h00);
         chk("reset_reg", 16'h0000, {er, rd});
      end
      chk("oe_reset", 16'h0003, 16'(ch_oe_n));
      apb(1'b0, 8'h3c, 8'h00);
      chk("unmapped", 16'h0100, {er, rd});
      $display("test reset done");
      v = 16'($random(seed));
      apb(1'b1, 8'h20, chsc(1'b0, timer_pwm_pkg::MS_OC));
      wr16(8'h24, v);
      rd16(8'h24);
      chk("oc_value_clk_off", v, g16);
      apb(1'b1, 8'h24, ~v[15:8]);
      apb(1'b1, 8'h20, chsc(1'b0, timer_pwm_pkg::MS_OC));
      apb(1'b1, 8'h28, ~v[7:0]);
      rd16(8'h24);
      chk("oc_discard", v, g16);
      $display("test buffer done");
      apb(1'b1, 8'h30, chsc(1'b0, timer_pwm_pkg::MS_IC));
      wr16(8'h34, 16'($random(seed)));
      rd16(8'h34);
      chk("ic_ignore", 16'h0000, g16);
      pin_en <= 1'b1;
      repeat (30) @(posedge pclk);
      pin_en <= 1'b0;
      apb(1'b0, 8'h30, 8'h00);
      chk("ic_flag", chsc(1'b1, timer_pwm_pkg::MS_IC), rd);
      $display("test capture done");
      m = 16'h0100 + (16'($random(seed)) & 16'h00ff);
      wr16(8'h0c, m);
      apb(1'b1, 8'h00, 8'h48);
      apb(1'b1, 8'h08, 8'h00);
      for (n = 0; irq !== 1'b1 && n < 2000; n++) @(posedge pclk);
      chk("ovf_period", 16'h0001, 16'(n >= m && n <= m + 5));
      apb(1'b1, 8'h00, 8'h48);
      apb(1'b0, 8'h00, 8'h00);
      chk("flag_kept", 16'h00c8, rd);
      apb(1'b1, 8'h00, 8'h48);
      apb(1'b0, 8'h00, 8'h00);
      chk("flag_clear", 16'h0048, rd);
      repeat (3) @(posedge pclk);
      chk("irq_low", 16'h0000, 16'(irq));
      apb(1'b1, 8'h20, chsc(1'b0, timer_pwm_pkg::MS_OC));
      wr16(8'h24, m >> 1);
      repeat (m + 8) @(posedge pclk);
      rd16(8'h24);
      chk("oc_value_clk_on", m >> 1, g16);
      apb(1'b0, 8'h20, 8'h00);
      chk("oc_flag", chsc(1'b1, timer_pwm_pkg::MS_OC), rd);
      $display("test overflow done");
      apb(1'b0, 8'h04, 8'h00);
      debug_halt <= 1'b1;
      apb(1'b1, 8'h08, 8'h00);
      apb(1'b0, 8'h08, 8'h00);
      chk("halt_live_low", 16'h0000, rd);
      repeat (10) @(posedge pclk);
      rd16(8'h04);
      chk("halt_frozen", 16'h0000, g16);
      $display("test halt done");
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      chk("pins_reset", 16'h0003, 16'({ch_out, ch_oe_n}));
      chk("irq_reset", 16'h0000, 16'(irq));
      apb(1'b0, 8'h00, 8'h00);
      chk("sc_reset", 16'h0000, {er, rd});
      apb(1'b0, 8'h20, 8'h00);
      chk("ch_sc_reset", 16'h0000, {er, rd});
      $display("test reset again done");
      test_done();
   end
endmodule : timer_pwm_irq_and_buffer_update_tb
